/* File: verilog/dasl_pkg.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: shared constants and types of the dual axis servo loop
// Assumes: 100 MHz core_clk, AHB-Lite register access, 32-bit words
// Notes:   printed register offsets are indices; byte address is index*4
//////////////////////////////////////////////////////////////////////////////
package dasl_pkg;

	localparam int          DASL_AXES          = 2;
	localparam int          DASL_CLK_MHZ       = 100;
	localparam int          DASL_PERIOD_US     = 500;
	localparam int          DASL_PERIOD_CYC    = DASL_PERIOD_US * DASL_CLK_MHZ;
	localparam int          DASL_AW            = 18;

	// printed register indices; each axis uses index + axis
	localparam logic [15:0] IDX_VEL_FF         = 16'h38a5;
	localparam logic [15:0] IDX_ACC_FF         = 16'h39d1;
	localparam logic [15:0] IDX_FILTER_SEL     = 16'h4269;
	// own registers: gains, command position, config and per-axis status
	localparam logic [15:0] IDX_PROP_GAIN      = 16'h4300;
	localparam logic [15:0] IDX_INT_GAIN       = 16'h4310;
	localparam logic [15:0] IDX_DER_GAIN       = 16'h4320;
	localparam logic [15:0] IDX_CMD_POS        = 16'h4330;
	localparam logic [15:0] IDX_CONFIG         = 16'h4340;
	localparam logic [15:0] IDX_ACT_POS        = 16'h4350;
	localparam logic [15:0] IDX_CMD_OUT        = 16'h4360;

	localparam logic [31:0] FILTER_SEL_FF      = 32'h0000_0005;
	localparam logic [31:0] REG_RESET          = 32'h0000_0000;
	localparam logic [15:0] CMD_MAX            = 16'h7fff;
	localparam logic [15:0] CMD_MIN            = 16'h8000;
	localparam logic [1:0]  HTRANS_NONSEQ      = 2'h2;

	typedef struct packed {
		logic chanA;
		logic chanB;
		logic index;
	} dasl_enc_t;

	typedef struct packed {
		logic signed [31:0] propGain;
		logic signed [31:0] intGain;
		logic signed [31:0] derGain;
		logic signed [31:0] accFf;
		logic signed [31:0] velFf;
		logic               ffSel;
		logic signed [31:0] cmdPos;
		logic               enable;
	} dasl_cfg_t;

endpackage : dasl_pkg

/* File: verilog/dasl_axis.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: one servo axis: quadrature decode and periodic filter
// Assumes: encoder pins already synchronised to core_clk
// Notes:   filter result is computed in one cycle at the period tick
//////////////////////////////////////////////////////////////////////////////
module dasl_axis
	import dasl_pkg::*;
(
	// clock and reset
	input  wire logic               core_clk,
	input  wire logic               rst,
	input  wire logic               clkEn,
	// encoder and timing
	input  wire dasl_enc_t          enc,
	input  wire logic               tick,
	input  wire logic               cfgLoad,
	input  wire dasl_cfg_t          cfg,
	// results
	output logic signed [31:0]      actPos_r,
	output logic signed [15:0]      cmdOut_r
);

	logic               prevA_r;
	logic               prevB_r;
	logic signed [31:0] accErr_r;
	logic signed [31:0] lastErr_r;
	logic signed [31:0] lastVel_r;
	logic signed [31:0] lastCmdPos_r;
	logic signed [31:0] posErr;
	logic signed [31:0] vel;
	logic signed [63:0] filt;
	logic signed [15:0] cmdOut_nxt;
	logic [1:0]         step;

	//////////////////////////////////////////////////////////////////////////
	// quadrature decode, x4: a leading b counts up
	assign step = {prevA_r ^ enc.chanB, enc.chanA ^ prevB_r};

	always_ff @(posedge core_clk) begin
		if (rst) begin
			prevA_r  <= 1'b0;
			prevB_r  <= 1'b0;
			actPos_r <= 32'sh0;
		end else if (clkEn) begin
			prevA_r <= enc.chanA;
			prevB_r <= enc.chanB;
			if (step == 2'b01)
				actPos_r <= actPos_r + 32'sh1;
			else if (step == 2'b10)
				actPos_r <= actPos_r - 32'sh1;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// filter
	assign posErr = cfg.cmdPos - actPos_r;
	assign vel    = cfg.cmdPos - lastCmdPos_r;

	always_comb begin
		// operands widened first so no product or difference wraps at 32 bits
		if (cfg.ffSel)
			filt = 64'(posErr) * 64'(cfg.propGain) + (64'(vel) - 64'(lastVel_r)) * 64'(cfg.accFf)
				+ 64'(vel) * 64'(cfg.velFf);
		else
			filt = 64'(posErr) * 64'(cfg.propGain) + (64'(posErr) - 64'(lastErr_r)) * 64'(cfg.derGain)
				+ 64'(accErr_r) * 64'(cfg.intGain);
		if (filt > 64'sd32767)
			cmdOut_nxt = CMD_MAX;
		else if (filt < -64'sd32768)
			cmdOut_nxt = CMD_MIN;
		else
			cmdOut_nxt = filt[15:0];
	end

	always_ff @(posedge core_clk) begin
		if (rst || (clkEn && cfgLoad)) begin
			accErr_r     <= 32'sh0;
			lastErr_r    <= 32'sh0;
			lastVel_r    <= 32'sh0;
			lastCmdPos_r <= cfg.cmdPos & {32{~rst}};
		end else if (clkEn && tick && cfg.enable) begin
			accErr_r     <= accErr_r + posErr;
			lastErr_r    <= posErr;
			lastVel_r    <= vel;
			lastCmdPos_r <= cfg.cmdPos;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			cmdOut_r <= 16'sh0;
		else if (clkEn && tick)
			cmdOut_r <= cfg.enable ? cmdOut_nxt : 16'sh0;
	end

endmodule : dasl_axis

/* File: verilog/dasl_servo.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: two-axis servo loop with AHB-Lite register slave
// Assumes: one clock, synchronous active-high reset
// Notes:   command code is signed 16-bit, -32768..32767 spans -10V..10V
//////////////////////////////////////////////////////////////////////////////
//
// The AHB-Lite interface to the registers was left to the implementer.

module dasl_servo
	import dasl_pkg::*;
(
	// clock and reset
	input  wire logic               core_clk,
	input  wire logic               rst,
	input  wire logic               clkEn,
	// ahb-lite slave
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic [31:0]             hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	// encoder pins, per axis
	input  wire logic [1:0]         encA,
	input  wire logic [1:0]         encB,
	input  wire logic [1:0]         indexPulseInput,
	// indicators {a, b, index} per axis
	output logic [2:0]              ledAxis0,
	output logic [2:0]              ledAxis1,
	// analog command codes
	output logic signed [15:0]      analogCommandOut0,
	output logic signed [15:0]      analogCommandOut1,
	// sticky flag per axis, set by the synchronised index
	output logic [1:0]              indexSeen
);

	dasl_enc_t          encS1_r [DASL_AXES];
	dasl_enc_t          encS2_r [DASL_AXES];
	dasl_cfg_t          cfg_r [DASL_AXES];
	logic [DASL_AXES-1:0] cfgLoad;
	logic signed [31:0] actPos [DASL_AXES];
	logic signed [15:0] cmdOut [DASL_AXES];
	logic [1:0]         idxSeen_r;
	logic [31:0]        tickCnt_r;
	logic               tick;
	logic               wrPend_r;
	logic [15:0]        wrIdx_r;
	logic [15:0]        aIdx;
	logic               aIsRd;
	logic [31:0]        rdData_r;

	//////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < DASL_AXES; i++) begin
				encS1_r[i] <= '0;
				encS2_r[i] <= '0;
			end
		end else if (clkEn) begin
			for (int i = 0; i < DASL_AXES; i++) begin
				encS1_r[i] <= '{encA[i], encB[i], indexPulseInput[i]};
				encS2_r[i] <= encS1_r[i];
			end
		end
	end

	assign ledAxis0 = {encS2_r[0].chanA, encS2_r[0].chanB, encS2_r[0].index};
	assign ledAxis1 = {encS2_r[1].chanA, encS2_r[1].chanB, encS2_r[1].index};

	//////////////////////////////////////////////////////////////////////////
	// 500 us update tick
	always_ff @(posedge core_clk) begin
		if (rst)
			tickCnt_r <= 32'h0;
		else if (clkEn)
			tickCnt_r <= tick ? 32'h0 : tickCnt_r + 32'h1;
	end
	assign tick = (tickCnt_r == 32'(DASL_PERIOD_CYC - 1));

	//////////////////////////////////////////////////////////////////////////
	// axes
	for (genvar g = 0; g < DASL_AXES; g++) begin : gAxis
		dasl_axis uAxis (
			.core_clk (core_clk),
			.rst      (rst),
			.clkEn    (clkEn),
			.enc      (encS2_r[g]),
			.tick     (tick),
			.cfgLoad  (cfgLoad[g]),
			.cfg      (cfg_r[g]),
			.actPos_r (actPos[g]),
			.cmdOut_r (cmdOut[g])
		);

		always_ff @(posedge core_clk) begin
			if (rst) begin
				idxSeen_r[g] <= 1'b0;
			end else if (clkEn && encS2_r[g].index) begin
				idxSeen_r[g] <= 1'b1;
			end
		end
	end

	assign analogCommandOut0 = cmdOut[0];
	assign analogCommandOut1 = cmdOut[1];
	assign indexSeen         = idxSeen_r;

	//////////////////////////////////////////////////////////////////////////
	// ahb-lite slave: zero wait states, always okay
	assign aIdx      = haddr[DASL_AW-1:2];
	assign aIsRd     = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdData_r;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wrPend_r <= 1'b0;
			wrIdx_r  <= 16'h0;
		end else if (clkEn) begin
			wrPend_r <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
			wrIdx_r  <= aIdx;
		end
	end

	// config write: each axis register sits at its base index plus the axis number
	always_ff @(posedge core_clk) begin
		cfgLoad <= '0;
		if (rst) begin
			for (int i = 0; i < DASL_AXES; i++)
				cfg_r[i] <= '0;
			cfgLoad <= '0;
		end else if (clkEn && wrPend_r) begin
			for (int i = 0; i < DASL_AXES; i++) begin
				if (wrIdx_r == IDX_VEL_FF + 16'(i))
					cfg_r[i].velFf <= hwdata;
				if (wrIdx_r == IDX_ACC_FF + 16'(i))
					cfg_r[i].accFf <= hwdata;
				if (wrIdx_r == IDX_FILTER_SEL + 16'(i))
					cfg_r[i].ffSel <= (hwdata == FILTER_SEL_FF);
				if (wrIdx_r == IDX_PROP_GAIN + 16'(i))
					cfg_r[i].propGain <= hwdata;
				if (wrIdx_r == IDX_INT_GAIN + 16'(i))
					cfg_r[i].intGain <= hwdata;
				if (wrIdx_r == IDX_DER_GAIN + 16'(i))
					cfg_r[i].derGain <= hwdata;
				if (wrIdx_r == IDX_CMD_POS + 16'(i))
					cfg_r[i].cmdPos <= hwdata;
				if (wrIdx_r == IDX_CONFIG + 16'(i)) begin
					cfg_r[i].enable <= hwdata[0];
					cfgLoad[i]      <= 1'b1;
				end
			end
		end
	end

	// read data registered for the data phase
	always_ff @(posedge core_clk) begin
		if (rst)
			rdData_r <= REG_RESET;
		else if (clkEn && aIsRd) begin
			rdData_r <= REG_RESET;
			for (int i = 0; i < DASL_AXES; i++) begin
				if (aIdx == IDX_VEL_FF + 16'(i))
					rdData_r <= cfg_r[i].velFf;
				if (aIdx == IDX_ACC_FF + 16'(i))
					rdData_r <= cfg_r[i].accFf;
				if (aIdx == IDX_FILTER_SEL + 16'(i))
					rdData_r <= cfg_r[i].ffSel ? FILTER_SEL_FF : REG_RESET;
				if (aIdx == IDX_PROP_GAIN + 16'(i))
					rdData_r <= cfg_r[i].propGain;
				if (aIdx == IDX_INT_GAIN + 16'(i))
					rdData_r <= cfg_r[i].intGain;
				if (aIdx == IDX_DER_GAIN + 16'(i))
					rdData_r <= cfg_r[i].derGain;
				if (aIdx == IDX_CMD_POS + 16'(i))
					rdData_r <= cfg_r[i].cmdPos;
				if (aIdx == IDX_CONFIG + 16'(i))
					rdData_r <= {31'h0, cfg_r[i].enable};
				if (aIdx == IDX_ACT_POS + 16'(i))
					rdData_r <= actPos[i];
				if (aIdx == IDX_CMD_OUT + 16'(i))
					rdData_r <= {{16{cmdOut[i][15]}}, cmdOut[i]};
			end
		end
	end

endmodule : dasl_servo

/* File: tb/dasl_servo_sva.sv */
// Purpose: port assertions of the two-axis servo loop
// Assumes: clkEn held high by the bench
// Notes:   two sync stages, leds driven straight from the second
module dasl_servo_sva
	import dasl_pkg::*;
(
	// clock and reset
	input wire logic               core_clk,
	input wire logic               rst,
	// bus answer
	input wire logic               hreadyout,
	input wire logic               hresp,
	// encoder and status
	input wire logic [1:0]         encA,
	input wire logic [1:0]         encB,
	input wire logic [1:0]         indexPulseInput,
	input wire logic [2:0]         ledAxis0,
	input wire logic [2:0]         ledAxis1,
	input wire logic [1:0]         indexSeen,
	// commands
	input wire logic signed [15:0] analogCommandOut0,
	input wire logic signed [15:0] analogCommandOut1
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	AST_LED_A0: assert property ($stable(encA[0])[*5] |-> ledAxis0[2] == encA[0])
		else $error("led a axis0 wrong");
	AST_LED_B1: assert property ($stable(encB[1])[*5] |-> ledAxis1[1] == encB[1])
		else $error("led b axis1 wrong");
	AST_LED_IDX1: assert property ($stable(indexPulseInput[1])[*5] |-> ledAxis1[0] == indexPulseInput[1])
		else $error("led index axis1 wrong");
	AST_IDX_SET: assert property (indexPulseInput[0][*5] |-> indexSeen[0])
		else $error("index not seen");
	AST_IDX_STICKY: assert property (indexSeen[1] |=> indexSeen[1])
		else $error("index seen dropped");
	AST_CMD0_HOLD: assert property ($changed(analogCommandOut0) |=> $stable(analogCommandOut0)[*8])
		else $error("command 0 not held");
	AST_CMD1_HOLD: assert property ($changed(analogCommandOut1) |=> $stable(analogCommandOut1)[*8])
		else $error("command 1 not held");
	AST_BUS_OKAY: assert property (hreadyout && !hresp)
		else $error("bus answer not okay");

	cover property ($changed(analogCommandOut0));
	cover property (analogCommandOut1 == 16'sh7fff);
	cover property ($rose(ledAxis1[1]));
endmodule : dasl_servo_sva

bind dasl_servo dasl_servo_sva u_dasl_servo_sva (.core_clk(core_clk), .rst(rst), .hreadyout(hreadyout),
	.hresp(hresp), .encA(encA), .encB(encB), .indexPulseInput(indexPulseInput), .ledAxis0(ledAxis0),
	.ledAxis1(ledAxis1), .indexSeen(indexSeen), .analogCommandOut0(analogCommandOut0),
	.analogCommandOut1(analogCommandOut1));

/* File: tb/dasl_enc_model.sv */
// Purpose: quadrature encoders of both axes
// Assumes: one step every four clocks
// Notes:   index high where position mod 64 is zero
module dasl_enc_model (
	input  wire logic               core_clk,
	input  wire logic signed [15:0] goal [2],
	output logic [1:0]              encA,
	output logic [1:0]              encB,
	output logic [1:0]              indexPulseInput,
	output logic                    idle
);
	timeunit 1ns;
	timeprecision 1ps;
	logic signed [15:0] pos [2] = '{16'sh0, 16'sh0};
	logic [1:0]         div = 2'h0;

	always @(posedge core_clk) begin
		div <= div + 2'h1;
		for (int a = 0; a < 2; a++) begin
			if (div == 2'h3 && goal[a] != pos[a]) begin
				pos[a] <= (goal[a] > pos[a]) ? pos[a] + 16'sh1 : pos[a] - 16'sh1;
			end
		end
	end

	always_comb begin
		for (int a = 0; a < 2; a++) begin
			encA[a] = pos[a][1] ^ pos[a][0];
			encB[a] = pos[a][1];
			indexPulseInput[a] = pos[a][5:0] == 6'h0;
		end
	end
	assign idle = pos[0] == goal[0] && pos[1] == goal[1];
endmodule : dasl_enc_model

/* File: tb/tb_top.sv */
// Purpose: self-checking bench of the servo loop
// Assumes: 100 MHz clock, two filter periods fit the run
// Notes:   bus master waits on hreadyout
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import dasl_pkg::*;
	logic               core_clk, rst, clkEn, hsel, hwrite, hready, hreadyout, hresp, idle;
	logic [31:0]        haddr, hwdata, hrdata;
	logic [1:0]         htrans, encA, encB, indexPulseInput, indexSeen;
	logic [2:0]         hsize, ledAxis0, ledAxis1;
	logic signed [15:0] analogCommandOut0, analogCommandOut1;
	logic signed [15:0] goal [2];
	int                 errTotal = 0;
	int                 testsRun = 0;

	dasl_servo u_dasl_servo (.core_clk(core_clk), .rst(rst), .clkEn(clkEn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .encA(encA), .encB(encB), .indexPulseInput(indexPulseInput),
		.ledAxis0(ledAxis0), .ledAxis1(ledAxis1), .analogCommandOut0(analogCommandOut0),
		.analogCommandOut1(analogCommandOut1), .indexSeen(indexSeen));
	dasl_enc_model u_dasl_enc_model (.core_clk(core_clk), .goal(goal), .encA(encA), .encB(encB),
		.indexPulseInput(indexPulseInput), .idle(idle));

	// single slave: its ready is the bus ready
	assign hready = hreadyout;

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		testsRun++;
		if (seen !== exp) begin
			errTotal++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= {14'h0, idx, 2'h0};
		hwrite <= wr;
		htrans <= HTRANS_NONSEQ;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic wr(input logic [15:0] idx, input logic [31:0] d);
		logic [31:0] rd;
		bus(1'b1, idx, d, rd);
	endtask : wr

	task automatic rdChk(input string what, input logic [15:0] idx, input logic [31:0] exp);
		logic [31:0] rd;
		bus(1'b0, idx, 32'h0, rd);
		check(what, rd, exp);
	endtask : rdChk

	task automatic waitTick;
		logic signed [15:0] prev;
		prev = analogCommandOut0;
		do @(posedge core_clk); while (analogCommandOut0 === prev);
	endtask : waitTick

	task automatic testRegs;
		rdChk("filterSel reset", IDX_FILTER_SEL, REG_RESET);
		wr(IDX_VEL_FF + 16'h1, 32'h0000_7fff);
		rdChk("velFf axis1", IDX_VEL_FF + 16'h1, 32'h0000_7fff);
		wr(IDX_ACC_FF, 32'h1234_5678);
		rdChk("accFf axis0", IDX_ACC_FF, 32'h1234_5678);
		wr(16'h0100, 32'hffff_ffff);
		rdChk("unmapped", 16'h0100, 32'h0);
		$display("test regs done");
	endtask : testRegs

	task automatic testEncoder;
		goal[0] <= 16'sh8;
		goal[1] <= -16'sh5;
		@(posedge core_clk);
		do @(posedge core_clk); while (idle !== 1'b1);
		repeat (8) @(posedge core_clk);
		rdChk("actPos0", IDX_ACT_POS, 32'h8);
		rdChk("actPos1", IDX_ACT_POS + 16'h1, 32'hffff_fffb);
		check("leds", {26'h0, ledAxis0, ledAxis1}, 32'h2);
		check("indexSeen", {30'h0, indexSeen}, 32'h3);
		$display("test encoder done");
	endtask : testEncoder

	task automatic testFilters;
		wr(IDX_PROP_GAIN, 32'h2);
		wr(IDX_INT_GAIN, 32'h1);
		wr(IDX_DER_GAIN, 32'h3);
		wr(IDX_CMD_POS, 32'h12);
		wr(IDX_FILTER_SEL + 16'h1, FILTER_SEL_FF);
		wr(IDX_PROP_GAIN + 16'h1, 32'h1);
		wr(IDX_INT_GAIN + 16'h1, 32'h64);
		wr(IDX_DER_GAIN + 16'h1, 32'h64);
		wr(IDX_ACC_FF + 16'h1, 32'h2);
		wr(IDX_VEL_FF + 16'h1, 32'h3);
		wr(IDX_CONFIG, 32'h1);
		wr(IDX_CONFIG + 16'h1, 32'h1);
		wr(IDX_CMD_POS + 16'h1, 32'h4);
		waitTick();
		check("pid first", {16'h0, analogCommandOut0}, 32'h32);
		check("ff first", {16'h0, analogCommandOut1}, 32'h1d);
		wr(IDX_PROP_GAIN + 16'h1, 32'h0001_0000);
		waitTick();
		check("pid second", {16'h0, analogCommandOut0}, 32'h1e);
		check("ff saturated", {16'h0, analogCommandOut1}, 32'h7fff);
		$display("test filters done");
	endtask : testFilters

	task automatic results;
		$display("comparisons %0d mismatches %0d", testsRun, errTotal);
		if (errTotal == 0 && testsRun > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	initial begin
		repeat (102000) @(posedge core_clk);
		errTotal++;
		results();
	end

	initial begin
		{rst, clkEn} = 2'h3;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		goal = '{16'sh0, 16'sh0};
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		testRegs();
		testEncoder();
		testFilters();
		results();
	end
endmodule : tb_top
